// >>> rtl/flash_port_defs.vh
// Constants for the serial flash programming port
// Definitions only; included by the port logic
`ifndef FLASH_PORT_DEFS_VH
`define FLASH_PORT_DEFS_VH
`define CLK_KHZ      50000
`define US_PER_MS    1000
`define WRITE_MS     5
`define ERASE_MS     5
`define LOCK_MS      40
`define LOAD_US      300
`define OP_SPECIAL   8'hAC
`define EN_BYTE2     8'h53
`define ERASE_BYTE2  7'h40
`define LOCK_BYTE2   6'h38
`define OP_CODE_RD   7'h10
`define OP_CODE_WR   7'h20
`define OP_SIG_RD    7'h18
`define OP_DATA_RD   6'h02
`define OP_DATA_WR   6'h12
`define SIG_LOC0     7'h30
`define SIG_LOC1     7'h31
`define SIG_NONE     8'h00
`define CODE_TOP     18'h00FFF
`define DATA_TOP     18'h2FFFF
`define ERASED       8'hFF
`define SECT_LSB     7
`define HDR_BIT      6'h17
`define OUT_BIT      6'h18
`define LAST_BIT     6'h1F
`define PROG_LOCK_B  1
`define VER_LOCK_B   0
`endif

// >>> rtl/link_sampler.v
// Two-flop synchronisers for the programming pins, plus shift clock edges
// Assumes every raw input is asynchronous to clk; rst is synchronous
`timescale 1ns/1ps
`default_nettype none
module link_sampler #(
	parameter N = 4
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [N-1:0] raw,
	output wire [N-1:0] lvl,
	output wire         rise,
	output wire         fall
);
	reg [N-1:0] meta_q;
	reg [N-1:0] sync_q;
	reg         last_q;

	// Bit 0 is the shift clock; edges come from the second stage only
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= {N{1'b0}};
			sync_q <= {N{1'b0}};
			last_q <= 1'b0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
			last_q <= sync_q[0];
		end
	end

	assign lvl  = sync_q;
	assign rise = sync_q[0] & ~last_q;
	assign fall = ~sync_q[0] & last_q;
endmodule // link_sampler
`default_nettype wire

// >>> rtl/flash_prog_port.v
// Serial programming engine for the code and data flash arrays
// Assumes an external array with a one-cycle read and pulse-driven
// byte write, sector erase and whole-chip erase on this clock.
`include "flash_port_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module flash_prog_port #(
	parameter        TW        = 22,
	parameter [31:0] WRITE_CYC = `WRITE_MS * `CLK_KHZ,
	parameter [31:0] ERASE_CYC = `ERASE_MS * `CLK_KHZ,
	parameter [31:0] LOCK_CYC  = `LOCK_MS * `CLK_KHZ,
	parameter [31:0] LOAD_CYC  = `LOAD_US * `CLK_KHZ / `US_PER_MS,
	parameter [7:0]  SIG_BYTE0 = 8'h5A, // Arbitrary identity value
	parameter [7:0]  SIG_BYTE1 = 8'hC3  // Arbitrary identity value
) (
	input  wire        CLOCK,
	input  wire        RST,
	input  wire        RESET_PIN,
	input  wire        PROGRAMMING_MODE_PIN,
	input  wire        SCK_PIN,
	input  wire        SERIAL_IN_PIN,
	output wire        SERIAL_OUT_PIN,
	output wire        READY_BUSY_OUTPUT,
	output wire        MEM_CODE,
	output wire [17:0] MEM_ADDR,
	output wire        MEM_RD,
	input  wire [7:0]  MEM_RDATA,
	output wire        MEM_WR,
	output wire [7:0]  MEM_WDATA,
	output wire        MEM_ERASE_SECTOR,
	output wire        MEM_ERASE_ALL
);
	// One-hot sequencer states
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_LOAD = 4'h2;
	localparam [3:0] S_PROG = 4'h4;
	localparam [3:0] S_WAIT = 4'h8;

	wire [3:0]    pins;
	wire          sck_rise;
	wire          sck_fall;
	wire          serial_in_pin;
	wire          mode_on;

	reg  [5:0]    cnt_q;
	reg  [22:0]   sh_q;
	reg  [23:0]   hdr_q;
	reg  [7:0]    data_q;
	reg           rd_go_q;
	reg           fr_go_q;
	reg  [7:0]    out_sr_q;
	reg  [7:0]    out_byte_q;
	reg           rd_pend_q;

	reg  [3:0]    state_q;
	reg  [TW-1:0] timer_q;
	reg  [TW-1:0] win_q;
	reg           enabled_q;
	reg           plock_q;
	reg           vlock_q;
	reg  [1:0]    lk_pend_q;
	reg           toggle_q;
	reg  [7:0]    last_wr_q;
	reg  [10:0]   sect_q;
	reg           code_q;
	reg  [7:0]    idx_q;
	reg  [7:0]    page_q [0:127];

	reg           mem_code_q;
	reg  [17:0]   mem_addr_q;
	reg           mem_rd_q;
	reg           mem_wr_q;
	reg  [7:0]    mem_wdata_q;
	reg           mem_er_sect_q;
	reg           mem_er_all_q;

	link_sampler #(
		.N(4)
	) u_sampler (
		.clk  (CLOCK),
		.rst  (RST),
		.raw  ({PROGRAMMING_MODE_PIN, RESET_PIN, SERIAL_IN_PIN, SCK_PIN}),
		.lvl  (pins),
		.rise (sck_rise),
		.fall (sck_fall)
	);

	assign serial_in_pin     = pins[1];
	assign mode_on = pins[2] & pins[3];

	// Frame header fields
	wire [7:0]  b1 = hdr_q[23:16];
	wire [7:0]  b2 = hdr_q[15:8];
	wire [7:0]  b3 = hdr_q[7:0];

	wire is_crd = (b1[7:1] == `OP_CODE_RD);
	wire is_cwr = (b1[7:1] == `OP_CODE_WR);
	wire is_sig = (b1[7:1] == `OP_SIG_RD);
	wire is_drd = (b1[7:2] == `OP_DATA_RD);
	wire is_dwr = (b1[7:2] == `OP_DATA_WR);
	wire is_code = is_crd | is_cwr;
	wire is_en    = (b1 == `OP_SPECIAL) && (b2 == `EN_BYTE2);
	wire is_erase = (b1 == `OP_SPECIAL) && (b2[7:1] == `ERASE_BYTE2);
	wire is_lock  = (b1 == `OP_SPECIAL) && (b2[7:2] == `LOCK_BYTE2);

	// Code space has twelve address bits, data space eighteen
	wire [17:0] addr = is_code ? {6'h00, b2[3:0], b3} : {b1[1:0], b2, b3};
	wire addr_ok = is_code ? (addr <= `CODE_TOP) : (addr <= `DATA_TOP);

	// Reads turn into status polls from the cycle the load window expires
	wire busy = state_q[2] | state_q[3];
	wire prog_start = (state_q == S_LOAD) && (win_q == {{(TW-1){1'b0}}, 1'b1});
	wire poll = busy | prog_start;

	// A write is refused while busy, program-locked, or outside its array
	wire wr_hit = enabled_q & (is_cwr | is_dwr) & addr_ok & ~plock_q & ~busy;
	// In the load phase only the first byte's array and sector are taken
	wire same_page = (code_q == is_cwr) && (sect_q == addr[17:`SECT_LSB]);
	wire load_we = fr_go_q & wr_hit &
		((state_q == S_IDLE) | ((state_q == S_LOAD) & same_page));
	// Signature locations other than the two defined ones read as zero
	wire [7:0] sig_val = (b3[6:0] == `SIG_LOC0) ? SIG_BYTE0 :
		(b3[6:0] == `SIG_LOC1) ? SIG_BYTE1 : `SIG_NONE;

	// Serial frame shifter, runs only while the mode pins are both high
	always @(posedge CLOCK) begin
		if (RST || !mode_on) begin
			cnt_q    <= 6'h00;
			sh_q     <= 23'h000000;
			hdr_q    <= 24'h000000;
			data_q   <= `ERASED;
			rd_go_q  <= 1'b0;
			fr_go_q  <= 1'b0;
			out_sr_q <= `ERASED;
		end else begin
			rd_go_q <= 1'b0;
			fr_go_q <= 1'b0;
			if (sck_rise) begin
				sh_q <= {sh_q[21:0], serial_in_pin};
				if (cnt_q == `HDR_BIT) begin
					hdr_q   <= {sh_q, serial_in_pin};
					rd_go_q <= 1'b1;
				end
				if (cnt_q == `LAST_BIT) begin
					cnt_q   <= 6'h00;
					data_q  <= {sh_q[6:0], serial_in_pin};
					fr_go_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 6'h01;
				end
			end
			// Answer byte enters the output register on the fall after the header
			if (sck_fall) begin
				if (cnt_q == `OUT_BIT) begin
					out_sr_q <= out_byte_q;
				end else begin
					out_sr_q <= {out_sr_q[6:0], 1'b1};
				end
			end
		end
	end

	// Page buffer, written in whatever order the bytes arrive
	always @(posedge CLOCK) begin
		if (load_we) begin
			page_q[b3[6:0]] <= data_q;
		end
	end

	// Read answers and the programming sequencer
	always @(posedge CLOCK) begin
		if (RST) begin
			state_q       <= S_IDLE;
			timer_q       <= {TW{1'b0}};
			win_q         <= {TW{1'b0}};
			enabled_q     <= 1'b0;
			plock_q       <= 1'b0;
			vlock_q       <= 1'b0;
			lk_pend_q     <= 2'h0;
			toggle_q      <= 1'b0;
			last_wr_q     <= `ERASED;
			sect_q        <= 11'h000;
			code_q        <= 1'b0;
			idx_q         <= 8'h00;
			out_byte_q    <= `ERASED;
			rd_pend_q     <= 1'b0;
			mem_code_q    <= 1'b0;
			mem_addr_q    <= 18'h00000;
			mem_rd_q      <= 1'b0;
			mem_wr_q      <= 1'b0;
			mem_wdata_q   <= `ERASED;
			mem_er_sect_q <= 1'b0;
			mem_er_all_q  <= 1'b0;
		end else begin
			mem_rd_q      <= 1'b0;
			mem_wr_q      <= 1'b0;
			mem_er_sect_q <= 1'b0;
			mem_er_all_q  <= 1'b0;
			// Array answers the cycle after its strobe; capture it then
			rd_pend_q     <= mem_rd_q;

			// Enable is lost as soon as either mode pin drops
			if (!mode_on) begin
				enabled_q <= 1'b0;
			end else if (fr_go_q && is_en) begin
				enabled_q <= 1'b1;
			end

			if (rd_pend_q) begin
				out_byte_q <= MEM_RDATA;
			end

			// Header decoded after the third byte; the answer must be in place
			// before the fall that opens the fourth byte
			if (rd_go_q) begin
				if (!enabled_q) begin
					out_byte_q <= `ERASED;
				end else if (is_sig) begin
					out_byte_q <= sig_val;
				end else if (!(is_crd || is_drd) || !addr_ok) begin
					out_byte_q <= `ERASED;
				end else if (poll) begin
					out_byte_q <= {~last_wr_q[7], toggle_q, last_wr_q[5:0]};
					toggle_q   <= ~toggle_q;
				end else if (plock_q && vlock_q) begin
					out_byte_q <= `ERASED;
				end else begin
					mem_rd_q   <= 1'b1;
					mem_code_q <= is_code;
					mem_addr_q <= addr;
				end
			end

			if (load_we) begin
				last_wr_q <= data_q;
			end

			case (state_q)
			S_IDLE: begin
				if (load_we) begin
					state_q <= S_LOAD;
					win_q   <= LOAD_CYC[TW-1:0];
					sect_q  <= addr[17:`SECT_LSB];
					code_q  <= is_cwr;
				end else if (fr_go_q && enabled_q && is_erase) begin
					// Chip erase also clears both lock bits at its start
					state_q      <= S_WAIT;
					timer_q      <= ERASE_CYC[TW-1:0];
					mem_er_all_q <= 1'b1;
					plock_q      <= 1'b0;
					vlock_q      <= 1'b0;
					lk_pend_q    <= 2'h0;
				end else if (fr_go_q && enabled_q && is_lock) begin
					// Lock bits take hold only when the timer runs out
					state_q   <= S_WAIT;
					timer_q   <= LOCK_CYC[TW-1:0];
					lk_pend_q <= ~b2[1:0];
				end
			end
			S_LOAD: begin
				// Every accepted byte restarts the load window
				if (load_we) begin
					win_q <= LOAD_CYC[TW-1:0];
				end else if (prog_start) begin
					state_q       <= S_PROG;
					timer_q       <= WRITE_CYC[TW-1:0];
					idx_q         <= 8'h00;
					mem_er_sect_q <= 1'b1;
					mem_code_q    <= code_q;
					mem_addr_q    <= {sect_q, 7'h00};
				end else begin
					win_q <= win_q - {{(TW-1){1'b0}}, 1'b1};
				end
			end
			S_PROG: begin
				// Sector erase pulse went out on entry; now every buffered byte
				// Bytes never loaded go out with stale buffer contents
				if (!idx_q[7]) begin
					mem_wr_q    <= 1'b1;
					mem_addr_q  <= {sect_q, idx_q[6:0]};
					mem_wdata_q <= page_q[idx_q[6:0]];
					idx_q       <= idx_q + 8'h01;
				end
				if (timer_q == {{(TW-1){1'b0}}, 1'b1}) begin
					state_q <= S_IDLE;
				end else begin
					timer_q <= timer_q - {{(TW-1){1'b0}}, 1'b1};
				end
			end
			S_WAIT: begin
				if (timer_q == {{(TW-1){1'b0}}, 1'b1}) begin
					state_q   <= S_IDLE;
					plock_q   <= plock_q | lk_pend_q[`PROG_LOCK_B];
					vlock_q   <= vlock_q | lk_pend_q[`VER_LOCK_B];
					lk_pend_q <= 2'h0;
				end else begin
					timer_q <= timer_q - {{(TW-1){1'b0}}, 1'b1};
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

	// Ready is low for the whole erase, program or lock cycle
	assign SERIAL_OUT_PIN    = out_sr_q[7];
	assign READY_BUSY_OUTPUT = ~busy;
	assign MEM_CODE          = mem_code_q;
	assign MEM_ADDR          = mem_addr_q;
	assign MEM_RD            = mem_rd_q;
	assign MEM_WR            = mem_wr_q;
	assign MEM_WDATA         = mem_wdata_q;
	assign MEM_ERASE_SECTOR  = mem_er_sect_q;
	assign MEM_ERASE_ALL     = mem_er_all_q;
endmodule // flash_prog_port
`default_nettype wire

// >>> verif/flash_port_props.sv
// Pin-level checks for the flash programming port
// Bound to flash_prog_port; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module flash_port_props #(
	parameter [31:0] WRITE_CYC = 32'h1,
	parameter [31:0] ERASE_CYC = 32'h1,
	parameter [31:0] LOCK_CYC  = 32'h1
) (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic        READY_BUSY_OUTPUT,
	input wire logic        MEM_CODE,
	input wire logic [17:0] MEM_ADDR,
	input wire logic        MEM_WR,
	input wire logic        MEM_ERASE_SECTOR,
	input wire logic        MEM_ERASE_ALL
);
	localparam [31:0] LO   = (ERASE_CYC < LOCK_CYC) ? ERASE_CYC : LOCK_CYC;
	localparam [31:0] MINB = (WRITE_CYC < LO) ? WRITE_CYC : LO;
	localparam [31:0] MAXB = WRITE_CYC + ERASE_CYC + LOCK_CYC;
	logic [31:0] busy_q;
	// Length of the current busy stretch
	always @(posedge CLOCK) begin
		busy_q <= (RST || READY_BUSY_OUTPUT) ? 32'h0 : busy_q + 32'h1;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	sequence sect_clear;
		MEM_ERASE_SECTOR;
	endsequence
	sequence wr_run;
		MEM_WR [*8];
	endsequence
	ready_wr_a: assert property (MEM_WR |-> !READY_BUSY_OUTPUT)
		else $error("write while ready");
	sector_run_a: assert property (sect_clear |-> ##[1:8] wr_run)
		else $error("no burst after sector erase");
	burst_sect_a: assert property (MEM_WR && $past(MEM_WR) |->
		$stable(MEM_CODE) && $stable(MEM_ADDR[17:7])) else $error("burst left sector");
	erase_idle_a: assert property (MEM_ERASE_ALL || MEM_ERASE_SECTOR |->
		$past(READY_BUSY_OUTPUT)) else $error("erase while busy");
	erase_busy_a: assert property (MEM_ERASE_ALL |-> ##[0:2] !READY_BUSY_OUTPUT)
		else $error("erase not busy");
	busy_min_a: assert property ($rose(READY_BUSY_OUTPUT) |-> busy_q + 32'h2 >= MINB)
		else $error("busy too short");
	busy_max_a: assert property (busy_q <= MAXB)
		else $error("busy too long");
	addr_range_a: assert property (MEM_WR |-> MEM_ADDR <= (MEM_CODE ? 18'h00FFF : 18'h2FFFF))
		else $error("write out of range");
endmodule // flash_port_props
bind flash_prog_port flash_port_props #(
	.WRITE_CYC(WRITE_CYC),
	.ERASE_CYC(ERASE_CYC),
	.LOCK_CYC(LOCK_CYC)
) chk (.CLOCK, .RST, .READY_BUSY_OUTPUT, .MEM_CODE, .MEM_ADDR, .MEM_WR, .MEM_ERASE_SECTOR,
	.MEM_ERASE_ALL);
`default_nettype wire

// >>> verif/flash_programmer.sv
// Behavioural serial programmer on the far side of the link
// Used through its xfer task; clk is the bench clock
`timescale 1ns/1ps
`default_nettype none
module flash_programmer (
	input  wire logic clk,
	output var  logic sck,
	output var  logic serial_in_pin,
	input  wire logic serial_out_pin
);
	initial {sck, serial_in_pin} = 2'b01;
	// One four-byte frame, MSB first; last byte comes back on sdo
	task automatic xfer(input logic [31:0] f, output logic [7:0] r);
		integer b;
		r = 8'h00;
		for (b = 31; b >= 0; b--) begin
			@(posedge clk);
			sck <= 1'b0;
			serial_in_pin <= f[b];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (3) @(posedge clk);
			if (b < 8) r = {r[6:0], serial_out_pin};
		end
		@(posedge clk);
		sck <= 1'b0;
		// Released line shows no stale value
		serial_in_pin <= ~serial_in_pin;
	endtask
endmodule // flash_programmer
`default_nettype wire

// >>> verif/test_flash_prog_port.sv
// Bench for the serial flash programming port
// Programmer model on the link, byte array model on the memory port
`timescale 1ns/1ps
`default_nettype none
module test_flash_prog_port;
	localparam       LOAD = 32'h258;
	localparam [7:0] SIG0 = 8'h96; // Arbitrary identity value
	localparam [7:0] SIG1 = 8'h69; // Arbitrary identity value
	logic        CLOCK = 1'b0;
	logic        RST = 1'b1;
	logic        RESET_PIN = 1'b0;
	logic        PROGRAMMING_MODE_PIN = 1'b0;
	logic [7:0]  MEM_RDATA = 8'h00;
	wire         SCK_PIN, SERIAL_IN_PIN, SERIAL_OUT_PIN, READY_BUSY_OUTPUT, MEM_CODE;
	wire         MEM_RD, MEM_WR, MEM_ERASE_SECTOR, MEM_ERASE_ALL;
	wire  [17:0] MEM_ADDR;
	wire  [7:0]  MEM_WDATA;
	logic [7:0]  mem [0:511];
	logic [7:0]  r, p;
	integer      bad_count = 0, checks = 0, wr_n = 0, era_n = 0, n, i, k;
	always #10 CLOCK = ~CLOCK;
	flash_prog_port #(.WRITE_CYC(32'h7D0), .ERASE_CYC(32'h32), .LOCK_CYC(32'h32),
		.LOAD_CYC(LOAD), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1)) dut (.CLOCK, .RST, .RESET_PIN,
		.PROGRAMMING_MODE_PIN, .SCK_PIN, .SERIAL_IN_PIN, .SERIAL_OUT_PIN, .READY_BUSY_OUTPUT,
		.MEM_CODE, .MEM_ADDR, .MEM_RD, .MEM_RDATA, .MEM_WR, .MEM_WDATA, .MEM_ERASE_SECTOR,
		.MEM_ERASE_ALL);
	flash_programmer pg (.clk(CLOCK), .sck(SCK_PIN), .serial_in_pin(SERIAL_IN_PIN), .serial_out_pin(SERIAL_OUT_PIN));
	// Array: read data valid the cycle after the strobe, noise otherwise
	always @(posedge CLOCK) begin
		MEM_RDATA <= MEM_RD ? mem[{MEM_CODE, MEM_ADDR[7:0]}] : ~MEM_RDATA;
		if (MEM_WR) begin
			mem[{MEM_CODE, MEM_ADDR[7:0]}] <= MEM_WDATA;
			wr_n <= wr_n + 1;
		end
		if (MEM_ERASE_ALL) begin
			for (k = 0; k < 512; k++) mem[k] <= 8'hFF;
			era_n <= era_n + 1;
		end
	end
	task check(input logic [31:0] s, input logic [31:0] e);
		checks = checks + 1;
		if (s !== e) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task stop_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wait_ready(input logic lvl, input integer lim);
		integer t;
		for (t = 0; t < lim && READY_BUSY_OUTPUT !== lvl; t++) @(posedge CLOCK);
		if (READY_BUSY_OUTPUT !== lvl) begin
			bad_count = bad_count + 1;
			stop_test;
		end
	endtask
	task settle;
		wait_ready(1'b0, 2000);
		wait_ready(1'b1, 6000);
	endtask
	task rd(input logic [31:0] f, input logic [7:0] e);
		pg.xfer(f, r);
		check({24'h0, r}, {24'h0, e});
	endtask
	initial begin
		for (i = 0; i < 512; i++) mem[i] = 8'h00;
		repeat (10) @(posedge CLOCK);
		RST <= 1'b0;
		RESET_PIN <= 1'b1;
		PROGRAMMING_MODE_PIN <= 1'b1;
		repeat (4) @(posedge CLOCK);
		rd(32'h200A8000, 8'hFF);
		pg.xfer(32'hAC53FFFF, r);
		pg.xfer(32'hAC800000, r);
		settle;
		check(era_n, 1);
		rd(32'h200A8000, 8'hFF);
		for (i = 127; i >= 0; i--) pg.xfer({16'h400A, 1'b1, i[6:0], i[7:0] ^ 8'hA5}, r);
		wait_ready(1'b0, 2000);
		pg.xfer(32'h200A8000, p);
		check({25'h0, p[7], p[5:0]}, 32'h25);
		pg.xfer(32'h200A8000, r);
		check({31'h0, r[6]}, {31'h0, ~p[6]});
		pg.xfer(32'hAC800000, r);
		settle;
		check(era_n, 1);
		check(wr_n, 128);
		rd(32'h200A8500, 8'hA0);
		rd(32'h200A8000, 8'hA5);
		pg.xfer(32'h4AFF803C, r);
		settle;
		rd(32'h0AFF8000, 8'h3C);
		n = wr_n;
		pg.xfer(32'h4B000011, r);
		repeat (LOAD + 200) @(posedge CLOCK);
		check(wr_n, n);
		rd(32'h30003000, SIG0);
		rd(32'h30003100, SIG1);
		rd(32'hFF000000, 8'hFF);
		pg.xfer(32'hACE10000, r);
		settle;
		pg.xfer(32'h400A8011, r);
		repeat (LOAD + 200) @(posedge CLOCK);
		check(wr_n, n);
		rd(32'h200A8000, 8'hA5);
		pg.xfer(32'hACE00000, r);
		settle;
		rd(32'h200A8000, 8'hFF);
		pg.xfer(32'hAC800000, r);
		settle;
		pg.xfer(32'h400A8077, r);
		settle;
		rd(32'h200A8000, 8'h77);
		stop_test;
	end
endmodule // test_flash_prog_port
`default_nettype wire
